// ### inc/smf_pkg.sv
package smf_pkg;
    localparam int          CLK_HZ_DEF  = 125_000_000;
    localparam int          AW          = 12;
    localparam int          NBAUD       = 6;
    localparam int          BAUD [NBAUD] = '{2400, 4800, 9600, 19200, 38400, 57600};
    localparam logic [2:0]  BAUD_DEF    = 3'h2;
    // register byte addresses
    localparam logic [11:0] A_CTRL      = 12'h000;
    localparam logic [11:0] A_STATION   = 12'h004;
    localparam logic [11:0] A_STATUS    = 12'h008;
    localparam logic [11:0] A_MASK      = 12'h00c;
    localparam logic [11:0] A_INFO      = 12'h010;
    localparam logic [11:0] A_TXDATA    = 12'h014;
    localparam logic [1:0]  A_BUF_HI    = 2'h1;
    // control fields
    localparam int          C_ASCII     = 0;
    localparam int          C_BAUD      = 1;
    localparam int          C_PAR_EN    = 4;
    localparam int          C_PAR_ODD   = 5;
    localparam int          C_EN        = 6;
    localparam logic [6:0]  CTRL_RST    = 7'h44;
    localparam logic [7:0]  STATION_RST = 8'h01;
    // status / mask bits, txdata raw bit
    localparam int          S_OK        = 0;
    localparam int          S_DROP      = 1;
    localparam int          S_CHERR     = 2;
    localparam int          S_TXDONE    = 3;
    localparam int          TX_RAW      = 8;
    // characters and check values
    localparam logic [7:0]  CH_COLON    = 8'h3a;
    localparam logic [7:0]  CH_CR       = 8'h0d;
    localparam logic [7:0]  CH_LF       = 8'h0a;
    localparam logic [7:0]  CH_0        = 8'h30;
    localparam logic [7:0]  CH_9        = 8'h39;
    localparam logic [7:0]  CH_A        = 8'h41;
    localparam logic [7:0]  CH_F        = 8'h46;
    localparam logic [7:0]  LRC_BASE    = 8'hff;
    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_POLY    = 16'ha001;
    // function codes and quantity limits
    localparam logic [7:0]  FC_READ     = 8'h03;
    localparam logic [7:0]  FC_WR1      = 8'h06;
    localparam logic [7:0]  FC_WRN      = 8'h10;
    localparam logic [15:0] QTY_READ    = 16'h000a;
    localparam logic [15:0] QTY_ASC     = 16'h0028;
    localparam logic [15:0] QTY_RTU     = 16'h0064;
    localparam logic [7:0]  MIN_ASC     = 8'h03;
    localparam logic [7:0]  MIN_RTU     = 8'h04;
    // character shape
    localparam logic [3:0]  DBITS_ASC   = 4'h7;
    localparam logic [3:0]  DBITS_RTU   = 4'h8;
    localparam logic [3:0]  FRAME_XTRA  = 4'h3;
    localparam int          SIL_CHARS   = 4;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1, RX_START = 4'h2, RX_BITS = 4'h4, RX_STOP = 4'h8
    } smf_rx_t;
    typedef enum logic [3:0] {
        FR_HUNT = 4'h1, FR_BODY = 4'h2, FR_LF = 4'h4, FR_SKIP = 4'h8
    } smf_fr_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h1, TX_SHIFT = 2'h2
    } smf_tx_t;
endpackage

// ### rtl/smf_framer.sv
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// [RULE1] ascii mode: each byte travels as two hex characters, high nibble first
// [RULE2] nibbles 0-9 map to 30h-39h, A-F map to 41h-46h
// [RULE3] rtu mode: each byte travels raw as one 8-bit character
// [RULE4] bit rate selectable 2400 to 57600 baud, same at both ends
// [RULE5] one low start bit, then 7 data bits ascii or 8 rtu
// [RULE6] optional parity; one stop bit with parity, two without
// [RULE7] lrc covers message bytes only, not colon nor cr/lf
// [RULE8] lrc is ff minus 8-bit carry-free sum, plus one
// [RULE9] rtu messages end with a 16-bit crc after the data
// [RULE10] function 03 reads holding registers, fewer than 10 per message
// [RULE11] function 06 writes one holding register
// [RULE12] function 16 writes 1-120 registers, below 40 ascii, below 100 rtu
// [RULE13] ascii message starts with colon 3ah before the address
// [RULE14] ascii message ends with cr 0dh then lf 0ah
// [RULE15] rtu message framed by four silent character times; crc low then high
// [RULE16] ascii message has same fields as rtu, lrc replacing crc
// [RULE17] ascii lrc sent as two characters before cr/lf
// [RULE18] act only on own address with good check, else discard silently
// [RULE19] parity or stop error flagged and current message rejected; an error on the closing lf is flagged but the message is still accepted
module smf_framer #(
    parameter int CLK_HZ = smf_pkg::CLK_HZ_DEF
) (
    input  wire logic                     CORE_CLK,
    input  wire logic                     SYS_RST,
    input  wire logic                     CORE_CE,
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [smf_pkg::AW-1:0]   PADDR,
    input  wire logic [31:0]              PWDATA,
    output logic      [31:0]              PRDATA,
    output logic                          PREADY,
    output logic                          PSLVERR,
    input  wire logic                     MB_RXD,
    output logic                          MB_TXD,
    output logic                          MB_DE,
    output logic                          IRQ
);
    import smf_pkg::*;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
        logic [6:0]  ctrl;
        logic [7:0]  station;
        logic [3:0]  status;
        logic [3:0]  mask;
        smf_rx_t     rx_st;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [8:0]  rx_sh;
        logic        rx_stop;
        logic        rx_bad;
        logic        rx_gap;
        logic [23:0] sil;
        smf_fr_t     fr_st;
        logic [7:0]  len;
        logic [7:0]  lrc;
        logic [15:0] crc;
        logic [3:0]  nib;
        logic        half;
        logic        ferr;
        logic [7:0]  addr;
        logic [7:0]  func;
        logic [15:0] qty;
        logic [7:0]  olen;
        logic [7:0]  ofunc;
        smf_tx_t     tx_st;
        logic [15:0] tx_cnt;
        logic [11:0] tx_sh;
        logic [3:0]  tx_left;
        logic        tx_pend;
        logic [7:0]  tx_lo;
        logic        txd;
        logic        de;
    } smf_state_t;

    localparam smf_state_t ST_RST = '{ctrl: CTRL_RST, station: STATION_RST, rx_st: RX_IDLE,
                                      fr_st: FR_HUNT, tx_st: TX_IDLE, crc: CRC_INIT,
                                      txd: 1'b1, default: '0};

    smf_state_t  st_reg;
    smf_state_t  st_next;
    logic [7:0]  mem [256];
    logic        mem_we;
    logic [7:0]  mem_wa;
    logic [7:0]  mem_wd;
    logic [15:0] div_tab [NBAUD];
    logic [15:0] div;
    logic [23:0] sil_lim;
    logic        ascii;
    logic [3:0]  dbits;
    logic        acc;
    logic        ch_done;
    logic        par_bad;
    logic [7:0]  ch;
    logic        tk;
    logic [7:0]  tb;
    logic        fr_rst;
    logic        fin;
    logic        chk_ok;
    logic        func_ok;
    logic        ok_ev;
    logic [3:0]  ev;
    logic [4:0]  hx;
    logic [15:0] cf;

    // =====================================================================
    // helpers
    // =====================================================================
    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a[11:10] == A_BUF_HI) || (a inside {A_CTRL, A_STATION, A_STATUS, A_MASK, A_INFO, A_TXDATA});
    endfunction

    function automatic logic [7:0] hex_chr(input logic [3:0] v);
        hex_chr = (v < 4'ha) ? CH_0 + {4'h0, v} : CH_A + {4'h0, v} - 8'h0a; // RULE2
    endfunction

    function automatic logic [4:0] hex_val(input logic [7:0] c);
        hex_val = '0;
        if (c >= CH_0 && c <= CH_9) begin
            hex_val = {1'b1, c[3:0]};
        end else if (c >= CH_A && c <= CH_F) begin
            hex_val = {1'b1, c[3:0] + 4'h9}; // RULE2
        end
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1); // RULE9
        end
        crc_step = r;
    endfunction

    // returns {bit count, line bits lsb first}
    function automatic logic [15:0] char_frame(input logic [7:0] b, input logic [6:0] c);
        logic [11:0] sh;
        logic [3:0]  d;
        d = c[C_ASCII] ? DBITS_ASC : DBITS_RTU; // RULE5
        sh = '1;
        sh[0] = 1'b0; // RULE5
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < d) begin
                sh[i + 1] = b[i];
            end
        end
        if (c[C_PAR_EN]) begin
            sh[d + 4'h1] = ^(c[C_ASCII] ? {1'b0, b[6:0]} : b) ^ c[C_PAR_ODD]; // RULE6
        end
        char_frame = {d + FRAME_XTRA, sh}; // RULE6
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < NBAUD; gi++) begin : g_div
            assign div_tab[gi] = 16'(CLK_HZ / BAUD[gi]); // RULE4
        end
    endgenerate

    assign ascii   = st_reg.ctrl[C_ASCII];
    assign dbits   = ascii ? DBITS_ASC : DBITS_RTU;
    assign div     = div_tab[(st_reg.ctrl[C_BAUD+:3] < 3'(NBAUD)) ? st_reg.ctrl[C_BAUD+:3] : BAUD_DEF];
    assign sil_lim = 24'(SIL_CHARS * (32'(dbits + FRAME_XTRA) * 32'(div))); // RULE15
    assign acc     = PSEL && PENABLE && st_reg.pready;
    assign hx      = hex_val(ch);

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        st_next = st_reg;
        mem_we  = 1'b0;
        mem_wa  = st_reg.len;
        mem_wd  = '0;
        ev      = '0;
        ch_done = 1'b0;
        tk      = 1'b0;
        tb      = '0;
        fr_rst  = 1'b0;
        fin     = 1'b0;
        ok_ev   = 1'b0;
        cf      = '0;
        ch      = ascii ? {1'b0, st_reg.rx_sh[6:0]} : st_reg.rx_sh[7:0];
        par_bad = st_reg.ctrl[C_PAR_EN] && ((^ch) ^ st_reg.ctrl[C_PAR_ODD] ^ st_reg.rx_sh[dbits]); // RULE6

        // apb slave: one wait state, answer registered
        st_next.pready  = PSEL && PENABLE && !st_reg.pready;
        if (PSEL && PENABLE && !st_reg.pready) begin
            st_next.pslverr = !addr_ok(PADDR);
            st_next.prdata  = '0;
            if (PADDR[11:10] == A_BUF_HI) begin
                st_next.prdata = {24'h0, mem[PADDR[9:2]]};
            end else begin
                unique case (PADDR)
                    A_CTRL:    st_next.prdata = {25'h0, st_reg.ctrl};
                    A_STATION: st_next.prdata = {24'h0, st_reg.station};
                    A_STATUS:  st_next.prdata = {28'h0, st_reg.status};
                    A_MASK:    st_next.prdata = {28'h0, st_reg.mask};
                    A_INFO:    st_next.prdata = {15'h0, st_reg.de, st_reg.ofunc, st_reg.olen};
                    default:   st_next.prdata = '0;
                endcase
            end
        end
        if (acc && PWRITE) begin
            unique case (PADDR)
                A_CTRL:    st_next.ctrl    = PWDATA[6:0];
                A_STATION: st_next.station = PWDATA[7:0];
                A_MASK:    st_next.mask    = PWDATA[3:0];
                default:   st_next.ctrl    = st_reg.ctrl;
            endcase
        end

        // receiver
        if (st_reg.rx_st != RX_IDLE || !MB_RXD) begin
            st_next.sil = '0;
        end else if (st_reg.sil < sil_lim) begin
            st_next.sil = st_reg.sil + 24'h1;
        end
        unique case (st_reg.rx_st)
            RX_IDLE: if (st_reg.ctrl[C_EN] && !MB_RXD) begin
                st_next.rx_st  = RX_START;
                st_next.rx_gap = st_reg.sil >= sil_lim; // RULE15
                st_next.rx_cnt = div >> 1;
            end
            RX_START: if (st_reg.rx_cnt == '0) begin
                st_next.rx_st  = MB_RXD ? RX_IDLE : RX_BITS; // RULE5
                st_next.rx_cnt = div - 16'h1;
                st_next.rx_bit = '0;
                st_next.rx_sh  = '0;
                st_next.rx_bad = 1'b0;
            end else begin
                st_next.rx_cnt = st_reg.rx_cnt - 16'h1;
            end
            RX_BITS: if (st_reg.rx_cnt == '0) begin
                st_next.rx_sh[st_reg.rx_bit] = MB_RXD;
                st_next.rx_cnt = div - 16'h1;
                st_next.rx_bit = st_reg.rx_bit + 4'h1;
                if (st_reg.rx_bit == dbits - 4'h1 + {3'h0, st_reg.ctrl[C_PAR_EN]}) begin
                    st_next.rx_st   = RX_STOP;
                    st_next.rx_stop = !st_reg.ctrl[C_PAR_EN]; // RULE6
                end
            end else begin
                st_next.rx_cnt = st_reg.rx_cnt - 16'h1;
            end
            RX_STOP: if (st_reg.rx_cnt == '0) begin
                st_next.rx_bad  = st_reg.rx_bad || !MB_RXD; // RULE19
                st_next.rx_cnt  = div - 16'h1;
                st_next.rx_stop = 1'b0;
                if (!st_reg.rx_stop) begin
                    ch_done       = 1'b1;
                    st_next.rx_st = RX_IDLE;
                end
            end else begin
                st_next.rx_cnt = st_reg.rx_cnt - 16'h1;
            end
        endcase

        // framing
        if (ch_done) begin
            if (st_next.rx_bad || par_bad) begin
                ev[S_CHERR] = 1'b1; // RULE19
            end
            if (!ascii) begin
                if (st_reg.rx_gap) begin
                    fr_rst        = 1'b1; // RULE15
                    st_next.fr_st = FR_BODY;
                end
                if (st_reg.rx_gap || st_reg.fr_st == FR_BODY) begin
                    tk = 1'b1; // RULE3
                    tb = ch;
                end
            end else if (!st_next.rx_bad && !par_bad && ch == CH_COLON) begin
                fr_rst        = 1'b1; // RULE13
                st_next.fr_st = FR_BODY;
            end else if (st_reg.fr_st == FR_BODY) begin
                if (ch == CH_CR) begin
                    st_next.fr_st = FR_LF; // RULE14
                end else if (hx[4]) begin
                    st_next.half = !st_reg.half; // RULE1
                    st_next.nib  = hx[3:0];
                    tk = st_reg.half;
                    tb = {st_reg.nib, hx[3:0]};
                end else begin
                    st_next.fr_st = FR_SKIP;
                end
            end else if (st_reg.fr_st == FR_LF) begin
                fin           = ch == CH_LF; // RULE14
                st_next.fr_st = FR_HUNT;
            end
            if (st_next.rx_bad || par_bad) begin
                st_next.ferr = 1'b1; // RULE19
            end
        end
        if (!ascii && st_reg.fr_st == FR_BODY && st_reg.rx_st == RX_IDLE && MB_RXD
            && st_reg.sil == sil_lim - 24'h1) begin
            fin           = 1'b1; // RULE15
            st_next.fr_st = FR_HUNT;
        end
        if (fr_rst) begin
            st_next.len  = '0;
            st_next.lrc  = '0;
            st_next.crc  = CRC_INIT;
            st_next.half = 1'b0;
            st_next.ferr = st_next.rx_bad || par_bad;
            st_next.qty  = '0;
            st_next.func = '0;
        end
        if (tk) begin
            if (st_next.len == 8'hff) begin
                st_next.ferr = 1'b1;
            end else begin
                mem_we      = 1'b1;
                mem_wa      = st_next.len;
                mem_wd      = tb;
                st_next.len = st_next.len + 8'h1;
                st_next.lrc = st_next.lrc + tb; // RULE7 RULE8
                st_next.crc = crc_step(st_next.crc, tb); // RULE9
                unique case (st_next.len)
                    8'h01:   st_next.addr      = tb;
                    8'h02:   st_next.func      = tb;
                    8'h05:   st_next.qty[15:8] = tb;
                    8'h06:   st_next.qty[7:0]  = tb;
                    default: st_next.addr      = st_next.addr;
                endcase
            end
        end
        // lrc byte included: carry-free sum then equals zero
        chk_ok = ascii ? (st_reg.lrc == '0 && st_reg.len >= MIN_ASC && !st_reg.half) // RULE8 RULE16
                       : (st_reg.crc == '0 && st_reg.len >= MIN_RTU); // RULE9 RULE15
        unique case (st_reg.func)
            FC_READ: func_ok = st_reg.qty != '0 && st_reg.qty < QTY_READ; // RULE10
            FC_WR1:  func_ok = 1'b1; // RULE11
            FC_WRN:  func_ok = st_reg.qty != '0 && st_reg.qty < (ascii ? QTY_ASC : QTY_RTU); // RULE12
            default: func_ok = 1'b0;
        endcase
        if (fin && st_reg.addr == st_reg.station) begin
            ok_ev        = chk_ok && func_ok && !st_reg.ferr; // RULE18
            ev[S_OK]     = ok_ev;
            ev[S_DROP]   = !ok_ev;
            if (ok_ev) begin
                st_next.olen  = st_reg.len - (ascii ? 8'h1 : 8'h2);
                st_next.ofunc = st_reg.func;
            end
        end

        // transmitter
        if (acc && PWRITE && PADDR == A_TXDATA && st_reg.tx_st == TX_IDLE) begin
            if (PWDATA[TX_RAW] || !ascii) begin
                cf = char_frame(PWDATA[7:0], st_reg.ctrl); // RULE3
                st_next.tx_pend = 1'b0;
            end else begin
                cf = char_frame(hex_chr(PWDATA[7:4]), st_reg.ctrl); // RULE1 RULE17
                st_next.tx_pend = 1'b1;
                st_next.tx_lo   = hex_chr(PWDATA[3:0]);
            end
        end else if (st_reg.tx_st == TX_SHIFT && st_reg.tx_cnt == '0) begin
            if (st_reg.tx_left != 4'h1) begin
                st_next.tx_sh   = {1'b1, st_reg.tx_sh[11:1]};
                st_next.txd     = st_reg.tx_sh[1];
                st_next.tx_left = st_reg.tx_left - 4'h1;
                st_next.tx_cnt  = div - 16'h1;
            end else if (st_reg.tx_pend) begin
                cf = char_frame(st_reg.tx_lo, st_reg.ctrl); // RULE1
                st_next.tx_pend = 1'b0;
            end else begin
                st_next.tx_st = TX_IDLE;
                st_next.txd   = 1'b1;
                st_next.de    = 1'b0;
                ev[S_TXDONE]  = 1'b1;
            end
        end else if (st_reg.tx_st == TX_SHIFT) begin
            st_next.tx_cnt = st_reg.tx_cnt - 16'h1;
        end
        if (cf != '0) begin
            st_next.tx_st   = TX_SHIFT;
            st_next.tx_sh   = cf[11:0];
            st_next.txd     = cf[0];
            st_next.tx_left = cf[15:12];
            st_next.tx_cnt  = div - 16'h1;
            st_next.de      = 1'b1;
        end

        // sticky status, write one to clear, set wins
        if (acc && PWRITE && PADDR == A_STATUS) begin
            st_next.status = st_reg.status & ~PWDATA[3:0];
        end
        st_next.status = st_next.status | ev;
        st_next.irq    = |(st_next.status & st_next.mask);
    end

    // =====================================================================
    // state registers
    // =====================================================================
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_reg <= ST_RST;
        end else if (CORE_CE) begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (CORE_CE && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign PRDATA  = st_reg.prdata;
    assign PREADY  = st_reg.pready;
    assign PSLVERR = st_reg.pslverr;
    assign MB_TXD  = st_reg.txd;
    assign MB_DE   = st_reg.de;
    assign IRQ     = st_reg.irq;

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST || !CORE_CE);

    a_own_addr: assert property (ok_ev |-> st_reg.addr == st_reg.station) // RULE18
        else $error("frame accepted for another station");
    a_start_low: assert property ($rose(st_reg.de) |-> !st_reg.txd) // RULE5
        else $error("character did not begin with a low start bit");
    a_hex_low: assert property ((acc && PWRITE && PADDR == A_TXDATA && st_reg.tx_st == TX_IDLE && ascii
        && !PWDATA[TX_RAW]) |=> st_reg.tx_pend && (st_reg.tx_lo inside {[CH_0:CH_9], [CH_A:CH_F]})) // RULE2
        else $error("low nibble not held as hex character");
    a_crc_good: assert property ((ok_ev && !ascii) |-> st_reg.crc == 16'h0000 && st_reg.len >= MIN_RTU) // RULE9
        else $error("rtu frame accepted with bad crc");
    a_lrc_good: assert property ((ok_ev && ascii) |-> st_reg.lrc == 8'h00) // RULE8
        else $error("ascii frame accepted with bad lrc");
    a_read_qty: assert property ((ok_ev && st_reg.func == FC_READ) |-> st_reg.qty != '0 && st_reg.qty < QTY_READ) // RULE10
        else $error("read accepted with bad register count");
    a_multi_qty: assert property ((ok_ev && st_reg.func == FC_WRN) // RULE12
        |-> st_reg.qty != '0 && st_reg.qty < (ascii ? QTY_ASC : QTY_RTU))
        else $error("multi write accepted with bad register count");
    a_char_err: assert property ((ch_done && par_bad) |=> st_reg.status[S_CHERR]) // RULE19
        else $error("parity error not flagged");
    a_err_reject: assert property ((ch_done && par_bad && st_reg.fr_st == FR_BODY) |=> st_reg.ferr) // RULE19
        else $error("bad character did not spoil frame");
    a_apb_wait: assert property ((PSEL && PENABLE && !st_reg.pready) |=> st_reg.pready ##1 !st_reg.pready)
        else $error("apb answer not a single cycle");

    c_ok_ascii: cover property (ok_ev && ascii);
    c_ok_rtu:   cover property (ok_ev && !ascii);
    c_drop:     cover property (ev[S_DROP]);
    c_tx_done:  cover property (ev[S_TXDONE] && ascii);
endmodule

// ### tb/smf_host.sv
`timescale 1ns/100ps
// ==========
// serial master model
module smf_host (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    int         div = 20;
    int         nb  = 8;
    bit         pe;
    logic [7:0] gb;
    event       got;
    initial rxd = 1'b1;
    task put(input logic [7:0] b, input bit bad);
        rxd <= 1'b0;
        repeat (div) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            rxd <= b[i];
            repeat (div) @(posedge clk);
        end
        if (pe) begin
            rxd <= ^(b & (nb == 8 ? 8'hff : 8'h7f)) ^ bad;
            repeat (div) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (pe ? div : 2 * div) @(posedge clk);
    endtask
    always begin
        @(negedge txd);
        repeat (div / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk);
            gb[i] = i < nb ? txd : 1'b0;
        end
        ->got;
    end
endmodule

// ### tb/smf_framer_test.sv
`timescale 1ns/100ps
// ==========
// bench
module smf_framer_test;
    import smf_pkg::*;
    logic        CORE_CLK = 1'b0;
    logic        SYS_RST  = 1'b1;
    logic        PSEL     = 1'b0;
    logic        PENABLE  = 1'b0;
    logic        PWRITE   = 1'b0;
    logic [11:0] PADDR    = '0;
    logic [31:0] PWDATA   = '0;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, MB_RXD, MB_TXD, MB_DE, IRQ;
    int          n_fail, tests_run;
    logic [32:0] rq[$];
    logic [7:0]  cq[$], fr[$];
    bit          pflip;
    always #4 CORE_CLK = ~CORE_CLK;
    smf_framer #(.CLK_HZ(1_152_000)) uut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CORE_CE(1'b1), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .MB_RXD(MB_RXD), .MB_TXD(MB_TXD), .MB_DE(MB_DE), .IRQ(IRQ));
    smf_host host (.clk(CORE_CLK), .txd(MB_TXD), .rxd(MB_RXD));
    task cmp(input logic [32:0] g, input logic [32:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask
    always @(posedge CORE_CLK) if (PSEL && PENABLE && PREADY && !PWRITE)
        cmp({PSLVERR, PRDATA}, rq.pop_front());
    always @(host.got) cmp({25'h0, host.gb}, {25'h0, cq.pop_front()});
    task apb(input bit w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        @(posedge CORE_CLK iff PREADY);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        crc = CRC_INIT;
        foreach (q[i]) begin
            crc ^= {8'h00, q[i]};
            repeat (8) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
        end
    endfunction
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'ha ? CH_0 + 8'(n) : CH_A + 8'(n) - 8'h0a;
    endfunction
    task hp(input logic [7:0] b);
        host.put(hx(b[7:4]), 1'b0);
        host.put(hx(b[3:0]), 1'b0);
    endtask
    task frame(input bit asc, input logic [7:0] bad);
        logic [7:0]  s;
        logic [15:0] c;
        s = 8'h00;
        foreach (fr[i]) s += fr[i];
        s = (8'hff - s + 8'h01) ^ bad;
        c = crc(fr) ^ {8'h00, bad};
        if (asc) begin
            host.put(CH_COLON, 1'b0);
            foreach (fr[i]) hp(fr[i]);
            hp(s);
            host.put(CH_CR, 1'b0);
            host.put(CH_LF, 1'b0);
        end else begin
            repeat (48 * host.div) @(posedge CORE_CLK);
            foreach (fr[i]) host.put(fr[i], pflip && i == 2);
            host.put(c[7:0], 1'b0);
            host.put(c[15:8], 1'b0);
            repeat (50 * host.div) @(posedge CORE_CLK);
        end
    endtask
    task txb(input logic [8:0] b);
        if (host.nb == 7 && !b[8]) cq.push_back(hx(b[7:4]));
        cq.push_back(host.nb == 7 && !b[8] ? hx(b[3:0]) : b[7:0]);
        apb(1'b1, A_TXDATA, {23'h0, b});
        @(negedge MB_DE);
    endtask
    task end_of_test;
        $display("fails %0d checks %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge CORE_CLK);
        n_fail++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'hba7c));
        repeat (5) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        rd(A_CTRL, 33'h044);
        rd(A_STATION, 33'h001);
        rd(12'h018, 33'h1_0000_0000);
        for (int s = 0; s < NBAUD; s++) begin
            host.div = 1_152_000 / BAUD[s];
            apb(1'b1, A_CTRL, 32'h40 | (s << 1));
            txb({1'b0, 8'($urandom)});
        end
        host.nb = 7;
        apb(1'b1, A_CTRL, 32'h4b);
        repeat (3) txb({1'b0, 8'($urandom)});
        txb({1'b1, CH_COLON});
        host.nb = 8;
        apb(1'b1, A_CTRL, 32'h4a);
        apb(1'b1, A_STATUS, 32'hf);
        apb(1'b1, A_MASK, 32'h1);
        fr = '{8'h01, 8'h06, 8'h00, 8'h65, 8'h00, 8'h05};
        frame(1'b0, 8'h00);
        cmp({32'h0, IRQ}, 33'h1);
        rd(A_INFO, 33'h0606);
        fr[0] = 8'h02;
        frame(1'b0, 8'h00);
        rd(A_STATUS, 33'h1);
        apb(1'b1, A_STATUS, 32'hf);
        repeat (2) @(posedge CORE_CLK);
        cmp({32'h0, IRQ}, 33'h0);
        fr[0] = 8'h01;
        frame(1'b0, 8'h5a);
        rd(A_STATUS, 33'h2);
        for (int q = 0; q < 4; q++) begin
            apb(1'b1, A_STATUS, 32'hf);
            fr = '{8'h01, q < 2 ? FC_READ : FC_WRN, 8'h00, 8'h65, 8'h00, 8'(q < 2 ? 9 + q : 97 + q)};
            frame(1'b0, 8'h00);
            rd(A_STATUS, q[0] ? 33'h2 : 33'h1);
        end
        host.nb = 7;
        apb(1'b1, A_CTRL, 32'h4b);
        apb(1'b1, A_STATUS, 32'hf);
        fr[5] = 8'h27;
        frame(1'b1, 8'h00);
        rd(A_STATUS, 33'h1);
        rd(12'h404, {25'h0, FC_WRN});
        host.nb = 8;
        host.pe = 1'b1;
        apb(1'b1, A_CTRL, 32'h5a);
        apb(1'b1, A_STATUS, 32'hf);
        frame(1'b0, 8'h00);
        rd(A_STATUS, 33'h1);
        apb(1'b1, A_STATUS, 32'hf);
        pflip = 1'b1;
        frame(1'b0, 8'h00);
        rd(A_STATUS, 33'h6);
        end_of_test;
    end
endmodule
